// file: rtl/adcsr_device.sv
// Converter end: conversion sequencing and serial result read-out.
//
// Operation
// - Works with clock parked high or low
// - After 16 bits, chip-select rise or clock fall restarts
// - Chip-select rise in output aborts, restarts conversion
// - Output high converting, low sleeping, select low
// - Host polls status only with idle-high clock
// - Conversion end enters sleep, result held, unless select and clock both low
// - Idle-high: seventeenth pulse fall starts conversion
// - Idle-low: sixteenth falling edge starts conversion
// - Idle-low host raises select after sixteenth rise
// - Select low shows MSB; rise discards rest
// - Clock edges ignored while converting
// - Two-wire host ties chip select low
// - Two-wire idle-high: output falls at sleep
// - Two-wire idle-low: skip sleep, MSB shown
// - Two-wire idle-low host relies on timing
// - Two-wire host checks output, forces with 16
// - Sleep until select and clock both low
// - MSB first, bit changes after falling edge
// - Fixed conversion time, at most 21 ms
`timescale 1ns/100ps
module adcsr_device
    import adcsr_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES
) (
    // Clock, reset and enable
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Serial link
    adcsr_link_if.dev                   link,
    // Conversion result from the filter
    input  wire logic [RESULT_BITS-1:0] result_i,
    // Status towards the local logic
    output logic                        converting_o,
    output logic                        sleeping_o,
    output logic                        outputting_o,
    output logic                        low_power_o,
    output logic                        conv_done_o,
    output logic                        abort_o
);

    // Refuse a conversion time the counter or the worst case cannot hold
    // A zero-length conversion would leave no time to latch the result
    generate
        if (CONV_CYC < 1 || CONV_CYC > CONV_MAX_CYCLES) begin : g_bad_conv
            $error("adcsr_device: CONV_CYC out of range");
        end
    endgenerate

    // Last count of the conversion and last counted clock fall
    localparam logic [CNT_W-1:0]    CONV_LAST = CNT_W'(CONV_CYC - 1);
    localparam logic [BITCNT_W-1:0] FALL_LAST = BITCNT_W'(RESULT_BITS - 1);

    // All state of the converter end
    // Kept in one record so that enable and reset treat every bit alike
    typedef struct packed {
        adcsr_dev_state_t       st;
        logic [2:0]             sck_sy;
        logic [2:0]             cs_sy;
        logic [CNT_W-1:0]       cnt;
        logic [BITCNT_W-1:0]    nfall;
        logic [RESULT_BITS-1:0] shreg;
        logic                   sdo;
        logic                   oe_n;
        logic                   done;
        logic                   abort;
    } adcsr_dev_t;

    // Reset starts a conversion with the line released and select read as high
    localparam adcsr_dev_t DEV_RST = '{
        st:     ADCSR_CONVERT,
        sck_sy: 3'h0,
        cs_sy:  3'h7,
        cnt:    '0,
        nfall:  '0,
        shreg:  '0,
        sdo:    1'h1,
        oe_n:   1'h1,
        done:   1'h0,
        abort:  1'h0
    };

    // Registered state and its next value
    adcsr_dev_t q;
    adcsr_dev_t next_q;

    // Synchronised pin levels and the edges found on them
    logic       sck_now;
    logic       sck_fall;
    logic       cs_now;
    logic       cs_rise;
    // Select and clock both low: the condition that opens the read-out
    logic       rd_enable;

    // The pins follow the host's timing, not ours: two stages settle them
    // before any decision, a third remembers the last level. Each level
    // must therefore stand for a few clocks, or its edge goes unseen.
    // Edge detection looks only at the second and third stages
    assign sck_now   = q.sck_sy[1];
    assign sck_fall  = q.sck_sy[2] & ~q.sck_sy[1];
    assign cs_now    = q.cs_sy[1];
    assign cs_rise   = ~q.cs_sy[2] & q.cs_sy[1];
    // Clock polarity is never configured: only the levels matter
    assign rd_enable = ~cs_now & ~sck_now;

    // Next-state logic of the sequencer
    // Cycle: convert, then sleep or read-out, then convert again. Only the
    // conversion counter, select and clock both low in sleep, a select rise or
    // the last counted clock fall move the state; every other pin activity is ignored.
    always_comb begin
        next_q        = q;
        next_q.sck_sy = {q.sck_sy[1:0], link.sck};
        next_q.cs_sy  = {q.cs_sy[1:0], link.cs_n};
        // Pulses last one cycle unless set again below
        next_q.done   = 1'h0;
        next_q.abort  = 1'h0;
        case (q.st)
            ADCSR_CONVERT: begin
                // Fixed-length conversion, link edges have no effect
                if (q.cnt == CONV_LAST) begin
                    next_q.cnt   = '0;
                    // Result taken once; later input changes wait for the next run
                    next_q.shreg = result_i;
                    next_q.done  = 1'h1;
                    next_q.nfall = '0;
                    if (rd_enable) begin
                        // Select tied low with clock low: straight to output
                        next_q.st = ADCSR_OUTPUT;
                    end else begin
                        // Park in sleep and hold the result
                        next_q.st = ADCSR_SLEEP;
                    end
                end else begin
                    next_q.cnt = q.cnt + 1'h1;
                end
            end
            ADCSR_SLEEP: begin
                // Leave sleep only once select and clock are both low
                // Select low with clock high only wakes the status line
                if (rd_enable) begin
                    next_q.st    = ADCSR_OUTPUT;
                    next_q.nfall = '0;
                end
            end
            ADCSR_OUTPUT: begin
                // A select rise outranks a clock fall in the same cycle
                if (cs_rise) begin
                    // Unsent bits dropped, new conversion at once
                    next_q.st    = ADCSR_CONVERT;
                    next_q.cnt   = '0;
                    next_q.abort = 1'h1;
                end else if (sck_fall) begin
                    // Falls count from the first one after entry
                    if (q.nfall == FALL_LAST) begin
                        // Sixteenth fall after entry restarts
                        next_q.st  = ADCSR_CONVERT;
                        next_q.cnt = '0;
                    end else begin
                        // Next bit after each falling edge, MSB first
                        next_q.nfall = q.nfall + 1'h1;
                        next_q.shreg = {q.shreg[RESULT_BITS-2:0], 1'h0};
                    end
                end
            end
            default: begin
                // Unused state code: recover by starting a conversion
                next_q.st  = ADCSR_CONVERT;
                next_q.cnt = '0;
            end
        endcase

        // Output level follows the state just entered
        // Deciding on the next state rather than the present one saves a
        // clock between the clock fall and the new bit
        case (next_q.st)
            ADCSR_CONVERT: next_q.sdo = 1'h1;
            ADCSR_SLEEP:   next_q.sdo = 1'h0;
            default:       next_q.sdo = next_q.shreg[RESULT_BITS-1];
        endcase
        // Line released while select is high, so a shared bus stays free
        // In two-wire use select never rises, so the line is always driven
        next_q.oe_n = cs_now;
    end

    // State register; enable low freezes everything
    // Reset is synchronous, so it too waits for a clock edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= DEV_RST;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    // Link and status outputs, all from flip-flops
    assign link.sdo_d    = q.sdo;
    assign link.sdo_oe_n = q.oe_n;
    // State decode for the local logic; at most one is high, none for the unused state code
    assign converting_o  = (q.st == ADCSR_CONVERT);
    assign sleeping_o    = (q.st == ADCSR_SLEEP);
    assign outputting_o  = (q.st == ADCSR_OUTPUT);
    // Low power needs sleep and a released select
    assign low_power_o   = (q.st == ADCSR_SLEEP) & q.cs_sy[2]; // Select high in sleep
    // One-cycle pulses for the result latch and a discarded read-out
    assign conv_done_o   = q.done;
    assign abort_o       = q.abort;

endmodule

// file: rtl/adcsr_host.sv
// Host end: drives select and serial clock, reads the 16-bit result.
`timescale 1ns/100ps
module adcsr_host
    import adcsr_pkg::*;
#(
    parameter int HALF     = SCK_HALF_CYCLES,
    parameter int POLL_CYC = POLL_LIMIT_CYCLES
) (
    // Clock, reset and enable
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   ce_i,
    // Serial link
    adcsr_link_if.host                  link,
    // Read command
    input  wire logic                   cmd_i,
    input  wire logic                   cpol_i,
    input  wire logic                   clk_end_i,
    input  wire logic                   poll_i,
    input  wire logic                   two_wire_i,
    input  wire logic [BITCNT_W-1:0]    nbits_i,
    // Answer
    output logic                        busy_o,
    output logic                        done_o,
    output logic                        timeout_o,
    output logic [RESULT_BITS-1:0]      data_o
);

    // The device needs several clocks to see an edge and answer
    generate
        if (HALF < SCK_HALF_MIN || HALF >= (1 << CNT_W)) begin : g_bad_half
            $error("adcsr_host: HALF out of range");
        end
        if (POLL_CYC < 1 || POLL_CYC >= (1 << CNT_W)) begin : g_bad_poll
            $error("adcsr_host: POLL_CYC out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0]    HALF_END = CNT_W'(HALF - 1);
    localparam logic [CNT_W-1:0]    POLL_END = CNT_W'(POLL_CYC - 1);
    localparam logic [BITCNT_W-1:0] NB_MAX   = BITCNT_W'(RESULT_BITS);

    // All state of the host end
    typedef struct packed {
        adcsr_host_state_t      st;
        logic                   cpol;
        logic                   clk_end;
        logic                   poll;
        logic                   two_wire;
        logic [BITCNT_W-1:0]    nbits;
        logic [BITCNT_W-1:0]    total;
        logic [BITCNT_W-1:0]    pc;
        logic [CNT_W-1:0]       tmr;
        logic                   cs_n;
        logic                   sck;
        logic [1:0]             sdo_sy;
        logic [RESULT_BITS-1:0] shreg;
        logic [RESULT_BITS-1:0] data;
        logic                   done;
        logic                   tout;
    } adcsr_host_t;

    localparam adcsr_host_t HOST_RST = '{
        st:       ADCSR_H_IDLE,
        cpol:     SCK_RST,
        clk_end:  1'h0,
        poll:     1'h0,
        two_wire: 1'h0,
        nbits:    '0,
        total:    '0,
        pc:       '0,
        tmr:      '0,
        cs_n:     CS_N_RST,
        sck:      SCK_RST,
        sdo_sy:   2'h3, // Released line idles high, so no false status
        shreg:    '0,
        data:     '0,
        done:     1'h0,
        tout:     1'h0
    };

    adcsr_host_t         q;
    adcsr_host_t         next_q;
    logic                sdo_s;
    logic                half_up;
    logic                take_bit;
    logic [BITCNT_W-1:0] nb_clamp;

    assign sdo_s    = q.sdo_sy[1];
    assign half_up  = (q.tmr == HALF_END);
    assign take_bit = (q.pc < q.nbits);
    assign nb_clamp = (nbits_i > NB_MAX) ? NB_MAX : nbits_i;

    // Transfer sequencing
    always_comb begin
        next_q        = q;
        next_q.sdo_sy = {q.sdo_sy[0], link.sdo};
        next_q.done   = 1'h0;
        next_q.tmr    = q.tmr + 1'h1;
        case (q.st)
            ADCSR_H_IDLE: begin
                next_q.tmr  = '0;
                next_q.sck  = q.cpol;
                next_q.cs_n = ~q.two_wire;
                if (cmd_i) begin
                    next_q.cpol     = cpol_i;
                    next_q.clk_end  = clk_end_i;
                    next_q.poll     = poll_i;
                    next_q.two_wire = two_wire_i;
                    next_q.nbits    = nb_clamp;
                    // Extra pulse count starts the conversion by clock
                    if (clk_end_i) begin
                        next_q.total = cpol_i ? BITCNT_W'(PULSES_IDLE_HIGH)
                                              : BITCNT_W'(PULSES_IDLE_LOW);
                    end else begin
                        next_q.total = nb_clamp;
                    end
                    next_q.pc    = '0;
                    next_q.shreg = '0;
                    next_q.tout  = 1'h0;
                    next_q.sck   = cpol_i;
                    next_q.cs_n  = 1'h0;
                    next_q.st    = ADCSR_H_SETUP;
                end
            end
            ADCSR_H_SETUP: begin
                if (half_up) begin
                    next_q.tmr = '0;
                    if (q.poll && q.cpol) begin
                        // Status polling only with clock parked high
                        next_q.st = ADCSR_H_POLL;
                    end else if (q.total == '0) begin
                        next_q.st = ADCSR_H_END;
                    end else begin
                        next_q.st = ADCSR_H_PA;
                    end
                end
            end
            ADCSR_H_POLL: begin
                if (!sdo_s) begin
                    // Output low marks a finished conversion
                    next_q.tmr = '0;
                    next_q.st  = (q.total == '0) ? ADCSR_H_END : ADCSR_H_PA;
                end else if (q.tmr == POLL_END) begin
                    // No answer in time: force a restart with bare pulses
                    next_q.tmr   = '0;
                    next_q.tout  = 1'h1;
                    next_q.nbits = '0;
                    next_q.total = BITCNT_W'(PULSES_FORCE);
                    next_q.st    = ADCSR_H_PA;
                end
            end
            ADCSR_H_PA: begin
                next_q.sck = ~q.cpol;
                if (half_up) begin
                    next_q.tmr = '0;
                    if (!q.cpol && take_bit) begin
                        next_q.shreg = {q.shreg[RESULT_BITS-2:0], sdo_s};
                    end
                    if (!q.cpol && !q.clk_end && q.pc == q.total - 1'h1) begin
                        // Raise select after the last rising edge
                        next_q.st = ADCSR_H_END;
                    end else begin
                        next_q.st = ADCSR_H_PB;
                    end
                end
            end
            ADCSR_H_PB: begin
                next_q.sck = q.cpol;
                if (half_up) begin
                    next_q.tmr = '0;
                    next_q.pc  = q.pc + 1'h1;
                    if (q.cpol && take_bit) begin
                        next_q.shreg = {q.shreg[RESULT_BITS-2:0], sdo_s};
                    end
                    next_q.st = (q.pc == q.total - 1'h1) ? ADCSR_H_END : ADCSR_H_PA;
                end
            end
            ADCSR_H_END: begin
                // Two-wire keeps select low throughout
                next_q.cs_n = ~q.two_wire;
                if (half_up) begin
                    next_q.tmr  = '0;
                    next_q.data = q.shreg;
                    next_q.done = 1'h1;
                    next_q.st   = ADCSR_H_IDLE;
                end
            end
            default: begin
                next_q.st = ADCSR_H_IDLE;
            end
        endcase
    end

    // State register; enable low freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= HOST_RST;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    assign link.cs_n = q.cs_n;
    assign link.sck  = q.sck;
    assign busy_o    = (q.st != ADCSR_H_IDLE);
    assign done_o    = q.done;
    assign timeout_o = q.tout;
    assign data_o    = q.data;

endmodule

// file: shared/adcsr_link_if.sv
// Three-wire link between the converter sequencer and its host.
`timescale 1ns/100ps
interface adcsr_link_if;
    logic cs_n;
    logic sck;
    logic sdo_d;
    logic sdo_oe_n;
    logic sdo;

    // Released line reads high through a pull-up
    assign sdo = sdo_oe_n ? 1'h1 : sdo_d;

    modport dev (
        input  cs_n,
        input  sck,
        output sdo_d,
        output sdo_oe_n
    );

    modport host (
        output cs_n,
        output sck,
        input  sdo
    );
endinterface

// file: shared/adcsr_pkg.sv
// Shared constants and state types of the serial read-out sequencer and its host.
package adcsr_pkg;

    // System clock rate
    localparam int CLK_FREQ_HZ       = 25_000_000;
    localparam int CLK_PER_US        = CLK_FREQ_HZ / 1_000_000;

    // Conversion timing, nominal and worst case, in microseconds
    localparam int CONV_TIME_US      = 16600;
    localparam int CONV_MAX_US       = 21000;
    localparam int CONV_CYCLES       = CONV_TIME_US * CLK_PER_US;
    localparam int CONV_MAX_CYCLES   = CONV_MAX_US * CLK_PER_US;

    // Result word and counter widths
    localparam int RESULT_BITS       = 16;
    localparam int BITCNT_W          = 5;
    localparam int CNT_W             = 20;

    // Serial clock made by the host: half period in system clocks
    localparam int SCK_HALF_CYCLES   = 8;
    localparam int SCK_HALF_MIN      = 6;

    // Longest wait for the end-of-conversion indication
    localparam int POLL_LIMIT_CYCLES = CONV_MAX_CYCLES;

    // Pulse counts for the clock-started conversions
    localparam int PULSES_IDLE_HIGH  = 17;
    localparam int PULSES_IDLE_LOW   = 16;
    localparam int PULSES_FORCE      = 16;

    // Reset levels of the link
    localparam logic CS_N_RST        = 1'h1;
    localparam logic SCK_RST         = 1'h1;

    // Device states
    typedef enum logic [1:0] {
        ADCSR_CONVERT,
        ADCSR_SLEEP,
        ADCSR_OUTPUT
    } adcsr_dev_state_t;

    // Host states
    typedef enum logic [2:0] {
        ADCSR_H_IDLE,
        ADCSR_H_SETUP,
        ADCSR_H_POLL,
        ADCSR_H_PA,
        ADCSR_H_PB,
        ADCSR_H_END
    } adcsr_host_state_t;

endpackage

// file: tb/adc_serial_readout_sequencer_bench.sv
// Self-checking bench: host and converter ends joined by the link.
`timescale 1ns/100ps
module adc_serial_readout_sequencer_bench import adcsr_pkg::*;;
    localparam int CONV = 200;
    localparam int POLL = 400;
    // Stimulus
    logic        clk_i, rst_i, ce_i, cmd_i, cpol_i, clk_end_i, poll_i, two_wire_i;
    logic [4:0]  nbits_i;
    logic [15:0] result_i;
    // Observed outputs
    logic        busy_o, done_o, timeout_o, converting_o, sleeping_o;
    logic        outputting_o, low_power_o, conv_done_o, abort_o;
    logic [15:0] data_o;
    int          error_cnt, num_checks, n_abort;

    adcsr_link_if adcsr_link_if_i ();
    adcsr_device #(.CONV_CYC(CONV)) adcsr_device_i (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(ce_i), .link(adcsr_link_if_i), .result_i(result_i),
        .converting_o(converting_o), .sleeping_o(sleeping_o), .outputting_o(outputting_o),
        .low_power_o(low_power_o), .conv_done_o(conv_done_o), .abort_o(abort_o));
    adcsr_host #(.POLL_CYC(POLL)) adcsr_host_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .link(adcsr_link_if_i), .cmd_i(cmd_i), .cpol_i(cpol_i), .clk_end_i(clk_end_i),
        .poll_i(poll_i), .two_wire_i(two_wire_i), .nbits_i(nbits_i), .busy_o(busy_o),
        .done_o(done_o), .timeout_o(timeout_o), .data_o(data_o));
    adcsr_chk #(.CONV_CYC(CONV)) adcsr_chk_i (.clk_i(clk_i), .rst_i(rst_i),
        .cs_n(adcsr_link_if_i.cs_n), .sck(adcsr_link_if_i.sck), .sdo(adcsr_link_if_i.sdo),
        .converting_o(converting_o), .sleeping_o(sleeping_o),
        .outputting_o(outputting_o), .conv_done_o(conv_done_o));

    // Clock
    initial begin
        clk_i = 1'h0;
        forever #20 clk_i = ~clk_i;
    end

    // Abort pulses counted so a scenario can tell a discard from a full read
    always @(posedge clk_i) begin
        if (abort_o === 1'h1) begin
            n_abort++;
        end
    end

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'h1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // One host command, held to the negative edge, then a bounded wait for done
    task automatic rd(input logic cp, ce, pl, tw, input logic [4:0] n);
        int k;
        @(negedge clk_i);
        cpol_i = cp;
        clk_end_i = ce;
        poll_i = pl;
        two_wire_i = tw;
        nbits_i = n;
        cmd_i = 1'h1;
        @(negedge clk_i);
        cmd_i = 1'h0;
        k = 0;
        while (done_o !== 1'h1 && k < 3000) begin
            @(negedge clk_i);
            k++;
        end
        check(done_o === 1'h1 && busy_o === 1'h0, "read never finished");
    endtask

    // Host waits for the conversion only when polling, so the bench waits out a conversion
    task automatic wt();
        repeat (CONV + 40) @(negedge clk_i);
    endtask

    task automatic t_poll();
        rd(1'h1, 1'h1, 1'h1, 1'h0, 5'h10);
        check(data_o === 16'hA5C3, "polled read");
        check(timeout_o === 1'h0, "poll timed out");
        $display("test poll done");
    endtask

    task automatic t_busy();
        result_i = 16'h3C5A;
        rd(1'h1, 1'h0, 1'h0, 1'h0, 5'h04);
        check(data_o[3:0] === 4'hF, "clocked while converting");
        wt();
        check(sleeping_o === 1'h1 && low_power_o === 1'h1, "not asleep");
        // Enable low: a command is not taken and the result stays parked
        ce_i = 1'h0;
        cmd_i = 1'h1;
        repeat (20) @(negedge clk_i);
        cmd_i = 1'h0;
        check(busy_o === 1'h0 && sleeping_o === 1'h1, "enable low did not freeze");
        ce_i = 1'h1;
        rd(1'h1, 1'h0, 1'h0, 1'h0, 5'h10);
        check(data_o === 16'h3C5A, "read after busy clocks");
        $display("test busy done");
    endtask

    task automatic t_low();
        result_i = 16'h8001;
        wt();
        rd(1'h0, 1'h1, 1'h0, 1'h0, 5'h10);
        check(data_o === 16'h8001, "idle-low clock end");
        result_i = 16'h7FFE;
        wt();
        rd(1'h0, 1'h0, 1'h0, 1'h0, 5'h10);
        check(data_o === 16'h7FFE, "idle-low select end");
        $display("test idle low done");
    endtask

    task automatic t_abort();
        int a;
        result_i = 16'hC3A5;
        wt();
        a = n_abort;
        rd(1'h1, 1'h0, 1'h0, 1'h0, 5'h04);
        check(data_o[3:0] === 4'hC, "partial read");
        check(n_abort == a + 1, "no abort pulse");
        result_i = 16'h1234;
        wt();
        rd(1'h1, 1'h1, 1'h0, 1'h0, 5'h10);
        check(data_o === 16'h1234, "read after abort");
        result_i = 16'hB00F;
        wt();
        a = n_abort;
        rd(1'h0, 1'h0, 1'h0, 1'h0, 5'h01);
        check(data_o[0] === 1'h1 && n_abort == a + 1, "top bit only");
        $display("test abort done");
    endtask

    task automatic t_two();
        result_i = 16'h5AA5;
        rd(1'h1, 1'h1, 1'h1, 1'h1, 5'h10);
        check(data_o === 16'h5AA5, "two-wire idle-high");
        result_i = 16'h0FF0;
        wt();
        rd(1'h0, 1'h1, 1'h0, 1'h1, 5'h10);
        check(data_o === 16'h0FF0, "two-wire idle-low");
        result_i = 16'hF00F;
        wt();
        check(outputting_o === 1'h1 && sleeping_o === 1'h0, "sleep not skipped");
        rd(1'h0, 1'h1, 1'h0, 1'h1, 5'h10);
        check(data_o === 16'hF00F, "second idle-low");
        $display("test two wire done");
    endtask

    // Two-wire line stuck high: the poll times out and sixteen pulses force a restart
    task automatic t_force();
        result_i = 16'hFFFF;
        wt();
        rd(1'h1, 1'h1, 1'h1, 1'h1, 5'h10);
        check(timeout_o === 1'h1 && data_o === 16'h0000, "no poll timeout");
        check(converting_o === 1'h1, "forced restart missing");
        $display("test force done");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under ten thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        $display("mismatch at %0t: watchdog", $time);
        summarize();
    end

    // Main sequence
    initial begin
        rst_i = 1'h1;
        ce_i = 1'h1;
        cmd_i = 1'h0;
        cpol_i = 1'h1;
        clk_end_i = 1'h1;
        poll_i = 1'h0;
        two_wire_i = 1'h0;
        nbits_i = 5'h10;
        result_i = 16'hA5C3;
        error_cnt = 0;
        num_checks = 0;
        n_abort = 0;
        repeat (5) @(negedge clk_i);
        rst_i = 1'h0;
        t_poll();
        t_busy();
        t_low();
        t_abort();
        t_two();
        t_force();
        summarize();
    end
endmodule

// file: tb/adcsr_chk.sv
// Assertions on the converter link and the converter's state outputs.
`timescale 1ns/100ps
module adcsr_chk #(
    parameter int CONV_CYC = 200
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Link signals
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic sdo,
    // Converter state
    input  wire logic converting_o,
    input  wire logic sleeping_o,
    input  wire logic outputting_o,
    input  wire logic conv_done_o
);
    logic [19:0] conv_cnt;
    logic [4:0]  fall_cnt;
    logic [3:0]  quiet_cnt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Helper counts; pin edges reach the converter a few clocks late, hence the slack below
    always_ff @(posedge clk_i) begin
        if (rst_i || !converting_o) begin
            conv_cnt <= '0;
        end else begin
            conv_cnt <= conv_cnt + 20'h1;
        end
        if (rst_i || !outputting_o) begin
            fall_cnt <= '0;
        end else if ($fell(sck)) begin
            fall_cnt <= fall_cnt + 5'h1;
        end
        if (rst_i || (!cs_n && !sck)) begin
            quiet_cnt <= '0;
        end else if (quiet_cnt != 4'hF) begin
            quiet_cnt <= quiet_cnt + 4'h1;
        end
    end

    conv_len_a: assert property (
        $fell(converting_o) |-> conv_cnt >= CONV_CYC - 2 && conv_cnt <= CONV_CYC + 2)
        else $error("conversion length off");
    ignore_sck_a: assert property (
        converting_o && conv_cnt < CONV_CYC - 4 |=> converting_o)
        else $error("conversion left early");
    done_rest_a: assert property (
        conv_done_o |-> ##[0:2] (sleeping_o || outputting_o))
        else $error("no sleep or output after conversion");
    sdo_busy_a: assert property (
        converting_o && $past(converting_o, 2) |-> sdo)
        else $error("data line low while converting");
    sdo_sleep_a: assert property (
        sleeping_o && $past(sleeping_o, 2) && !cs_n && !$past(cs_n, 4) |-> !sdo)
        else $error("data line high while sleeping");
    sleep_hold_a: assert property (
        sleeping_o && quiet_cnt >= 4'h5 |=> sleeping_o)
        else $error("sleep left without select and clock low");
    out_entry_a: assert property (
        sleeping_o && !cs_n && !sck |-> ##[1:5] outputting_o)
        else $error("output not entered");
    restart_fall_a: assert property (
        outputting_o && fall_cnt == 5'h10 |-> ##[1:6] converting_o)
        else $error("no restart after sixteen falls");
    abort_cs_a: assert property (
        outputting_o && $rose(cs_n) |-> ##[1:6] (converting_o && !outputting_o))
        else $error("select rise did not restart");
endmodule
